// ===== verilog/fieldbus_regs.svh
// Purpose: Offsets, codes, reset values and timing counts for the
//          fieldbus remote station block.
// Assumes: 8-bit register address, 32-bit data, 100 MHz clock.
// Notes:   Definitions only.
`ifndef FIELDBUS_REGS_SVH
`define FIELDBUS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_OCC_SEL 8'h00
`define OFS_OCC_ACT 8'h04
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_FUNC_MAP 8'h10
`define OFS_BASE 8'h14

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_DRV_RESET 0
`define CTRL_STATION_LSB 8
`define ACT_MULT_LSB 16
`define ACT_PLC 20
`define ACT_LEGACY 21
`define ACT_VER2 22
`define OCC_RST 16'h0000
`define STATION_RST 8'h01
`define FUNC_MAP_RST 21'h1a_c688

// ****************************************************************
// Occupancy codes
// ****************************************************************
`define OCC_V1_LEGACY 16'h0000
`define OCC_V1 16'h0001
`define OCC_V2_X2 16'h000c
`define OCC_V2_X4 16'h000e
`define OCC_V2_X8 16'h0012
`define OCC_PLC_V1 16'h0064
`define OCC_PLC_X4 16'h0072
`define OCC_PLC_X8 16'h0076

// ****************************************************************
// Refresh period limits
// ****************************************************************
`define CLK_MHZ 100
`define REFRESH_MIN_US 3500
`define REFRESH_MAX_US 18000
`define REFRESH_MIN_CYC (`REFRESH_MIN_US * `CLK_MHZ)
`define REFRESH_MAX_CYC (`REFRESH_MAX_US * `CLK_MHZ)

`endif

// ===== verilog/fieldbus_pkg.sv
// Purpose: Types shared by the fieldbus remote station files.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Last field of each struct is bit 0.
package fieldbus_pkg;

    typedef enum logic [1:0] {
        CMD_CYCLIC,
        CMD_PROG_RD,
        CMD_PROG_WR,
        CMD_IDLE
    } link_cmd_t;

    typedef struct packed {
        logic tgl;
        link_cmd_t cmd;
        logic [7:0] station;
        logic [31:0] ry;
        logic [63:0] rww;
    } link_in_t;

    typedef struct packed {
        logic out_stop;
        logic restart;
        logic current_input_sel;
        logic second_function_sel;
        logic jog;
        logic low_speed_cmd;
        logic middle_speed_cmd;
        logic high_speed_cmd;
        logic rev;
        logic fwd;
    } drive_cmd_t;

    typedef struct packed {
        logic digital_output_zero;
        logic fault_contact_two;
        logic fault_contact_one;
        logic frequency_detect;
        logic momentary_power_loss;
        logic overload_alarm;
        logic up_to_frequency;
        logic running;
        logic rev_run;
        logic fwd_run;
    } drive_sts_t;

    typedef struct packed {
        logic wr_refused;
        logic prog_rej;
        logic per_err;
        logic stale;
    } status_t;

    typedef struct packed {
        logic valid;
        logic legacy;
        logic plc;
        logic ver2;
        logic [3:0] mult;
    } mode_t;

    typedef struct packed {
        link_in_t s1;
        link_in_t s2;
        logic tgl_prev;
        logic [31:0] ry;
        logic [63:0] rww;
        logic [31:0] rx;
        logic ack;
        logic [15:0] occ_pend;
        logic [15:0] occ_act;
        logic [7:0] station;
        logic [20:0] fmap;
        logic [20:0] cnt;
        logic seen;
        status_t sts;
        drive_cmd_t cmd;
        logic [15:0] cin;
        logic [31:0] rdata;
    } top_st_t;

endpackage : fieldbus_pkg

// ===== verilog/occupancy_decode.sv
// Purpose: Decode an occupancy setting into link mode fields.
// Assumes: Purely combinational.
// Notes:   Unlisted codes come out with valid low.
`timescale 1ns/1ps
`include "fieldbus_regs.svh"
module occupancy_decode (
    input wire logic [15:0] code,
    output fieldbus_pkg::mode_t mode
);
    always_comb begin
        mode = '0;
        mode.valid = 1'b1;
        mode.mult = 4'h1;
        case (code)
            `OCC_V1_LEGACY: mode.legacy = 1'b1;
            `OCC_V1: mode.legacy = 1'b0;
            `OCC_V2_X2: begin
                mode.ver2 = 1'b1;
                mode.mult = 4'h2;
            end
            `OCC_V2_X4: begin
                mode.ver2 = 1'b1;
                mode.mult = 4'h4;
            end
            `OCC_V2_X8: begin
                mode.ver2 = 1'b1;
                mode.mult = 4'h8;
            end
            `OCC_PLC_V1: mode.plc = 1'b1;
            `OCC_PLC_X4: begin
                mode.plc = 1'b1;
                mode.ver2 = 1'b1;
                mode.mult = 4'h4;
            end
            `OCC_PLC_X8: begin
                mode.plc = 1'b1;
                mode.ver2 = 1'b1;
                mode.mult = 4'h8;
            end
            default: mode = '0;
        endcase
    end
endmodule : occupancy_decode

// ===== verilog/word_bank.sv
// Purpose: Bank of link word registers copied on a load pulse.
// Assumes: load is a one-cycle pulse on clk.
// Notes:   Output is registered.
`timescale 1ns/1ps
module word_bank #(
    parameter int N = 4,
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [N*W-1:0] d,
    output logic [N*W-1:0] q
);
    logic [N*W-1:0] q_d;

    always_comb begin
        q_d = load ? d : q;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= q_d;
        end
    end
endmodule : word_bank

// ===== verilog/fieldbus_remote_io_map.sv
// Purpose: Remote station end of a cyclic fieldbus link in a drive.
// Assumes: Link pins come from another domain; drive and controller
//          signals run on clk.
// Notes:   Frames are marked by a toggle; data must be stable first.
//
// What this block does
// - Watch refresh period; flag periods under 3.5 ms or over 18 ms.
// - Link refresh runs free of the master's program timing.
// - Program read or write requests over the link are refused.
// - Codes 0, 1, 12, 14, 18 decode to non-controller link modes.
// - Codes 100, 114, 118 expose link points to the controller.
// - New occupancy takes effect only at the next drive reset.
// - 32 bits each way, 16 for controller, 4 words each way.
// - Received bits 0 and 1 run forward/reverse, mirrored to inputs in codes 100, 114, 118.
// - Received bits 2 to 8 drive default functions, mirrored in codes 100, 114, 118.
// - In codes 0, 1, 12, 14, 18, transmit bits 5 to 9 carry power loss, frequency detect, fault and output status.
// - Only frames for the configured station are taken; base reported.
// - Bits 0, 1, 9 fixed; bits 2 to 8 reassignable.
// - Word registers copied to and from controller at each scan end.
`timescale 1ns/1ps
`include "fieldbus_regs.svh"
module fieldbus_remote_io_map #(
    parameter int unsigned MIN_CYC = `REFRESH_MIN_CYC,
    parameter int unsigned MAX_CYC = `REFRESH_MAX_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire fieldbus_pkg::link_in_t link_in,
    output logic [31:0] link_rx,
    output logic [63:0] link_rwr,
    output logic link_ack_tgl,
    input wire fieldbus_pkg::drive_sts_t drive_sts,
    input wire logic [15:0] ctrl_out,
    input wire logic [63:0] ctrl_rw_out,
    input wire logic scan_end,
    output fieldbus_pkg::drive_cmd_t drive_cmd,
    output logic [15:0] ctrl_in,
    output logic [63:0] ctrl_rw_in
);
    fieldbus_pkg::top_st_t q;
    fieldbus_pkg::top_st_t n;
    fieldbus_pkg::mode_t wmode;
    fieldbus_pkg::mode_t amode;
    logic frame;
    logic cyclic;
    logic lost;
    logic [31:0] tx_img;
    logic [6:0] func;
    logic [9:0] c;

    // ************************************************************
    // Occupancy decoding
    // ************************************************************
    occupancy_decode u_wdec (
        .code(wdata[15:0]),
        .mode(wmode)
    );

    occupancy_decode u_adec (
        .code(q.occ_act),
        .mode(amode)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = q;
        // Whole frame word crosses through two flops; the toggle
        // guard keeps it unused while its bits may still settle
        n.s1 = link_in;
        n.s2 = q.s1;
        n.tgl_prev = q.s2.tgl;
        frame = (q.s2.tgl != q.tgl_prev) && (q.s2.station == q.station);
        cyclic = frame && (q.s2.cmd == fieldbus_pkg::CMD_CYCLIC);
        lost = (q.cnt == 21'(MAX_CYC));
        if (amode.plc) begin
            tx_img = {16'h0000, ctrl_out};
        end else begin
            tx_img = {22'h00_0000, drive_sts};
        end
        if (!lost) begin
            n.cnt = q.cnt + 21'h00_0001;
        end
        if (frame) begin
            n.ack = ~q.ack;
        end
        // Program images never cross the link, only cyclic data
        if (cyclic) begin
            n.cnt = '0;
            n.seen = 1'b1;
            n.ry = q.s2.ry;
            n.rww = q.s2.rww;
            n.rx = tx_img;
        end

        // Reassignable functions: each of bits 2..8 picks a slot
        for (int f = 0; f < 7; f++) begin
            func[f] = 1'b0;
            for (int i = 0; i < 7; i++) begin
                if (q.fmap[3*i +: 3] == 3'(f) && q.ry[i+2]) begin
                    func[f] = 1'b1;
                end
            end
        end
        c = {q.ry[9], func, q.ry[1:0]};
        // Commands drop if the master stops refreshing
        n.cmd = fieldbus_pkg::drive_cmd_t'(lost ? 10'h000 : c);
        n.cin = amode.plc ? q.ry[15:0] : 16'h0000;

        // Register writes
        if (wr) begin
            case (addr)
                `OFS_OCC_SEL: begin
                    if (wmode.valid) begin
                        n.occ_pend = wdata[15:0];
                    end
                end
                `OFS_CTRL: begin
                    n.station = wdata[`CTRL_STATION_LSB +: 8];
                    if (wdata[`CTRL_DRV_RESET]) begin
                        n.occ_act = q.occ_pend;
                    end
                end
                `OFS_STATUS: n.sts = q.sts & ~wdata[3:0];
                `OFS_FUNC_MAP: n.fmap = wdata[20:0];
                default: n.fmap = q.fmap;
            endcase
        end

        // Sticky flags: a set in the clearing cycle wins
        if (wr && addr == `OFS_OCC_SEL && !wmode.valid) begin
            n.sts.wr_refused = 1'b1;
        end
        if (frame && !cyclic && q.s2.cmd != fieldbus_pkg::CMD_IDLE) begin
            n.sts.prog_rej = 1'b1;
        end
        if (cyclic && q.seen && q.cnt < 21'(MIN_CYC)) begin
            n.sts.per_err = 1'b1;
        end
        if (lost) begin
            n.sts.stale = 1'b1;
        end

        // Read data stand only in the cycle after the strobe
        n.rdata = '0;
        if (rd) begin
            case (addr)
                `OFS_OCC_SEL: n.rdata = {16'h0000, q.occ_pend};
                `OFS_OCC_ACT: begin
                    n.rdata = {16'h0000, q.occ_act};
                    n.rdata[`ACT_MULT_LSB +: 4] = amode.mult;
                    n.rdata[`ACT_PLC] = amode.plc;
                    n.rdata[`ACT_LEGACY] = amode.legacy;
                    n.rdata[`ACT_VER2] = amode.ver2;
                end
                `OFS_CTRL: n.rdata = {16'h0000, q.station, 8'h00};
                `OFS_STATUS: n.rdata = {28'h000_0000, q.sts};
                `OFS_FUNC_MAP: n.rdata = {11'h000, q.fmap};
                `OFS_BASE: n.rdata = {19'h0_0000, 8'(q.station - 8'h01),
                    5'h00};
                default: n.rdata = '0;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.occ_pend <= `OCC_RST;
            q.occ_act <= `OCC_RST;
            q.station <= `STATION_RST;
            q.fmap <= `FUNC_MAP_RST;
        end else begin
            q <= n;
        end
    end

    // ************************************************************
    // Word registers, copied at each controller scan end
    // ************************************************************
    word_bank #(.N(4), .W(16)) u_rx_words (
        .clk(clk),
        .rstn(rstn),
        .load(scan_end),
        .d(q.rww),
        .q(ctrl_rw_in)
    );

    word_bank #(.N(4), .W(16)) u_tx_words (
        .clk(clk),
        .rstn(rstn),
        .load(scan_end),
        .d(ctrl_rw_out),
        .q(link_rwr)
    );

    assign rdata = q.rdata;
    assign link_rx = q.rx;
    assign link_ack_tgl = q.ack;
    assign drive_cmd = q.cmd;
    assign ctrl_in = q.cin;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    refused_write_a: assert property (
        wr && addr == `OFS_OCC_SEL && !wmode.valid |=>
        $stable(q.occ_pend) && q.sts.wr_refused)
        else $error("bad occupancy code was accepted");

    mode_hold_a: assert property (
        !(wr && addr == `OFS_CTRL && wdata[`CTRL_DRV_RESET]) |=>
        $stable(q.occ_act))
        else $error("active mode moved without drive reset");

    prog_reject_a: assert property (
        frame && q.s2.cmd != fieldbus_pkg::CMD_CYCLIC |=>
        $stable(q.ry) && $stable(q.rx))
        else $error("program request changed link data");

    fixed_bits_a: assert property (
        !lost |=> drive_cmd.fwd == $past(q.ry[0]) &&
        drive_cmd.rev == $past(q.ry[1]) &&
        drive_cmd.out_stop == $past(q.ry[9]))
        else $error("fixed command bit mismatch");

    ctrl_mirror_a: assert property (
        amode.plc ##1 $stable(q.occ_act) |->
        ctrl_in == $past(q.ry[15:0]))
        else $error("controller input mirror mismatch");

    tx_source_a: assert property (
        cyclic && amode.plc |=> link_rx[15:0] == $past(ctrl_out))
        else $error("transmit bits not from controller outputs");

    stale_flag_a: assert property (
        lost |=> q.sts.stale && drive_cmd == '0)
        else $error("lost refresh not flagged");

    station_gate_a: assert property (
        q.s2.tgl != q.tgl_prev && q.s2.station != q.station |=>
        $stable(link_ack_tgl) && $stable(q.ry))
        else $error("frame for other station taken");

    scan_copy_a: assert property (
        scan_end |=> ctrl_rw_in == $past(q.rww) &&
        link_rwr == $past(ctrl_rw_out))
        else $error("word registers not copied at scan end");

    ack_toggle_a: assert property (
        frame |=> link_ack_tgl != $past(link_ack_tgl))
        else $error("frame for this station not acknowledged");

    cyclic_latch_a: assert property (
        cyclic |=> q.ry == $past(q.s2.ry) &&
        q.rww == $past(q.s2.rww))
        else $error("cyclic frame data not latched");

    period_flag_a: assert property (
        cyclic && q.seen && q.cnt < 21'(MIN_CYC) |=> q.sts.per_err)
        else $error("short refresh period not flagged");

    plc_gate_a: assert property (
        !amode.plc |=> ctrl_in == 16'h0000)
        else $error("controller inputs fed outside controller mode");

    tx_status_a: assert property (
        cyclic && !amode.plc |=>
        link_rx == {22'h00_0000, $past(drive_sts)})
        else $error("transmit bits not from drive status");

    occ_legal_a: assert property (
        amode.valid)
        else $error("active occupancy code is not a listed one");

    decode_x8_a: assert property (
        wdata[15:0] == `OCC_V2_X8 |->
        wmode.valid && wmode.ver2 && !wmode.plc && wmode.mult == 4'h8)
        else $error("octuple code decoded wrongly");

endmodule : fieldbus_remote_io_map

// ===== bench/fieldbus_master_model.sv
// Purpose: Master station model that drives the fieldbus link pins.
// Assumes: The bench asks for each frame; no program timing involved.
// Notes:   Data pins go inverse once the hold time has run out.
`timescale 1ns/1ps
module fieldbus_master_model (
    input wire logic clk,
    input wire logic [31:0] link_rx,
    output fieldbus_pkg::link_in_t link_in
);
    // ****************************************************************
    // Buffer memory and refresh
    // ****************************************************************
    logic [31:0] rx_buf;

    initial begin
        link_in = '0;
        rx_buf = '0;
    end

    // Started on request; the refresh itself needs no program step
    task automatic send(input fieldbus_pkg::link_cmd_t cmd,
        input logic [7:0] stn, input logic [31:0] ry,
        input logic [63:0] rww, input int gap);
        @(posedge clk);
        link_in.cmd <= cmd;
        link_in.station <= stn;
        link_in.ry <= ry;
        link_in.rww <= rww;
        repeat (3) @(posedge clk);
        link_in.tgl <= ~link_in.tgl;
        repeat (3) @(posedge clk);
        // Hold over: leave no stale copy on the pins
        link_in.ry <= ~ry;
        link_in.rww <= ~rww;
        repeat (2) @(posedge clk);
        rx_buf = link_rx;
        repeat (gap) @(posedge clk);
    endtask : send
endmodule : fieldbus_master_model

// ===== bench/fieldbus_remote_io_map_bench.sv
// Purpose: Self-checking bench for the fieldbus remote station block.
// Assumes: Refresh limits cut to 20 and 100 cycles to keep the run short.
// Notes:   Link pins come from the master model.
`timescale 1ns/1ps
`include "fieldbus_regs.svh"
module fieldbus_remote_io_map_bench;
    logic clk, rstn, wr, rd, scan_end, link_ack_tgl, old;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, link_rx, v, seen_rx;
    logic [63:0] link_rwr, ctrl_rw_out, ctrl_rw_in;
    logic [15:0] ctrl_out, ctrl_in;
    fieldbus_pkg::link_in_t link_in;
    fieldbus_pkg::drive_sts_t drive_sts;
    fieldbus_pkg::drive_cmd_t drive_cmd;
    int bad_count, num_checks, cyc;

    fieldbus_remote_io_map #(.MIN_CYC(20), .MAX_CYC(100))
        i_fieldbus_remote_io_map (.clk, .rstn, .addr, .wdata, .wr, .rd,
        .rdata, .link_in, .link_rx, .link_rwr, .link_ack_tgl, .drive_sts,
        .ctrl_out, .ctrl_rw_out, .scan_end, .drive_cmd, .ctrl_in,
        .ctrl_rw_in);
    fieldbus_master_model i_fieldbus_master_model (.clk, .link_rx,
        .link_in);

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string n, input logic [63:0] e, g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string n, input logic e, g);
        chk(n, {63'h0, e}, {63'h0, g});
    endtask : chk_bit

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic frame(input fieldbus_pkg::link_cmd_t c,
        input logic [7:0] s, input logic [31:0] ry, input int gap);
        old = link_ack_tgl;
        i_fieldbus_master_model.send(c, s, ry, 64'h1111_2222_3333_4444,
            gap);
        seen_rx = i_fieldbus_master_model.rx_buf;
    endtask : frame

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [7:0] a [6] = '{`OFS_OCC_SEL, `OFS_CTRL, `OFS_STATUS,
            `OFS_FUNC_MAP, `OFS_BASE, 8'h18};
        logic [31:0] e [6] = '{32'h0, 32'h0000_0100, 32'h0,
            32'h001a_c688, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++) begin
            rd_reg(a[i]);
            chk("reset reg", {32'h0, e[i]}, {32'h0, v});
        end
        chk("reset cmd", 64'h0, 64'(drive_cmd));
        $display("test reset done");
    endtask : t_reset

    task automatic t_decode();
        logic [15:0] c [8] = '{16'h0000, 16'h0001, 16'h000c, 16'h000e,
            16'h0012, 16'h0064, 16'h0072, 16'h0076};
        logic [6:0] m [8] = '{7'h21, 7'h01, 7'h42, 7'h44, 7'h48, 7'h11,
            7'h54, 7'h58};
        for (int i = 0; i < 8; i++) begin
            wr_reg(`OFS_OCC_SEL, {16'h0, c[i]});
            rd_reg(`OFS_OCC_ACT);
            chk("occ held", 64'(c[i - (i > 0)]), 64'(v[15:0]));
            wr_reg(`OFS_CTRL, 32'h0000_0101);
            rd_reg(`OFS_OCC_ACT);
            chk("occ mode", {41'h0, m[i], c[i]}, {32'h0, v});
        end
        wr_reg(`OFS_STATUS, 32'h0000_000f);
        wr_reg(`OFS_OCC_SEL, 32'h0000_0005);
        rd_reg(`OFS_OCC_SEL);
        chk("occ kept", 64'h0076, {32'h0, v});
        rd_reg(`OFS_STATUS);
        chk_bit("refused flag", 1'b1, v[3]);
        $display("test decode done");
    endtask : t_decode

    task automatic t_io();
        logic [3:0] stn_mult = 4'h8; // Station set to octuple
        rd_reg(`OFS_OCC_ACT);
        chk("mult", 64'(stn_mult), 64'(v[19:16]));
        @(posedge clk);
        drive_sts <= 10'h2aa;
        ctrl_out <= 16'h1234;
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h01, 32'habcd_0255, 20);
        chk_bit("ack", ~old, link_ack_tgl);
        chk("cmd", 64'h0255, 64'(drive_cmd));
        chk("ctrl in", 64'h0255, 64'(ctrl_in));
        chk("tx ctrl", 64'h1234, 64'(seen_rx));
        wr_reg(`OFS_OCC_SEL, 32'h0000_0001);
        wr_reg(`OFS_CTRL, 32'h0000_0101);
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h01, 32'h0000_03aa, 20);
        chk("cmd v1", 64'h03aa, 64'(drive_cmd));
        chk("ctrl in v1", 64'h0, 64'(ctrl_in));
        chk("tx sts", 64'h02aa, 64'(seen_rx));
        wr_reg(`OFS_FUNC_MAP, 32'h001a_c681);
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h01, 32'h0000_0207, 20);
        chk("remap", 64'h020b, 64'(drive_cmd));
        $display("test io done");
    endtask : t_io

    task automatic t_reject();
        // Idle frames last: acknowledged but never flagged
        for (int i = 1; i < 4; i++) begin
            wr_reg(`OFS_STATUS, 32'h0000_000f);
            frame(fieldbus_pkg::link_cmd_t'(i), 8'h01, 32'h0000_0001, 2);
            chk_bit("prog ack", ~old, link_ack_tgl);
            chk("prog data", 64'h020b, 64'(drive_cmd));
            rd_reg(`OFS_STATUS);
            chk_bit("prog flag", i < 3, v[2]);
        end
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h05, 32'h0000_0001, 0);
        chk_bit("foreign", old, link_ack_tgl);
        wr_reg(`OFS_STATUS, 32'h0000_000f);
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h01, 32'h0000_0001, 0);
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h01, 32'h0000_0001, 0);
        rd_reg(`OFS_STATUS);
        chk_bit("short period", 1'b1, v[1]);
        wr_reg(`OFS_STATUS, 32'h0000_000f);
        repeat (110) @(posedge clk);
        chk("stale cmd", 64'h0, 64'(drive_cmd));
        rd_reg(`OFS_STATUS);
        chk_bit("stale flag", 1'b1, v[0]);
        $display("test reject done");
    endtask : t_reject

    task automatic t_scan();
        @(posedge clk);
        ctrl_rw_out <= 64'h0123_4567_89ab_cdef;
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h01, 32'h0, 20);
        scan_end <= 1'b1;
        @(posedge clk);
        scan_end <= 1'b0;
        @(posedge clk);
        #1 chk("words out", 64'h0123_4567_89ab_cdef, link_rwr);
        chk("words in", 64'h1111_2222_3333_4444, ctrl_rw_in);
        wr_reg(`OFS_CTRL, 32'h0000_0300);
        rd_reg(`OFS_BASE);
        chk("base", 64'h0040, {32'h0, v});
        frame(fieldbus_pkg::CMD_CYCLIC, 8'h03, 32'h0, 20);
        chk_bit("station ack", ~old, link_ack_tgl);
        $display("test scan done");
    endtask : t_scan

    // ****************************************************************
    // Clock, reset, sequence and timeout
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        scan_end = 1'b0;
        drive_sts = '0;
        ctrl_out = '0;
        ctrl_rw_out = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_decode();
        t_io();
        t_reject();
        t_scan();
        final_report();
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end
endmodule : fieldbus_remote_io_map_bench
